// ---- hw/pci_bridge_pkg.sv ----
// Shared constants and carrier types for the posted write forwarding core
package pci_bridge_pkg;

  // ----------------------------------------
  // Bus commands and address constants
  // ----------------------------------------
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0] CMD_MEM_WRITE_INV = 4'hf;
  localparam logic [31:0] VGA_LO = 32'h000a_0000;
  localparam logic [31:0] VGA_HI = 32'h000b_ffff;
  localparam logic [31:0] DWORD_STEP = 32'h0000_0004;
  localparam logic [9:0] PAGE_LAST_WORD = 10'h3ff;

  // ----------------------------------------
  // Buffer and timing counts
  // ----------------------------------------
  localparam int POST_DEPTH = 32;
  localparam int MABORT_CYC = 5;
  localparam int LEVEL_W = 6;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  // One buffer entry: an address entry (first) or a data word
  typedef struct packed {
    logic first;
    logic last;
    logic [3:0] be_n;
    logic [31:0] dw;
  } post_entry_t;

  // Sampled bus pins of one PCI bus
  typedef struct packed {
    logic frame_n;
    logic irdy_n;
    logic trdy_n;
    logic stop_n;
    logic devsel_n;
    logic gnt_n;
    logic [3:0] cbe_n;
    logic [31:0] ad;
  } pci_in_t;

  // Target-side drive onto one bus
  typedef struct packed {
    logic devsel_n;
    logic trdy_n;
    logic stop_n;
    logic oe_n;
  } tgt_out_t;

  // Master-side drive onto one bus
  typedef struct packed {
    logic req_n;
    logic frame_n;
    logic irdy_n;
    logic ctl_oe_n;
    logic [3:0] cbe_n;
    logic [31:0] ad;
    logic ad_oe_n;
  } mst_out_t;

  // Decode settings for one direction
  typedef struct packed {
    logic [31:0] base;
    logic [31:0] limit;
    logic vga_en;
    logic [7:0] lat_timer;
  } dir_cfg_t;

endpackage

// ---- hw/pci_bridge_write_forwarding.sv ----
// Posted memory write buffer and two-direction posted write forwarding core
//
// Summary of operation
// RULE1: Never start or claim interrupt acknowledge.
// RULE2: Never issue or claim reserved command codes.
// RULE3: Never claim special cycle commands.
// RULE4: Special cycles go via Type 1 writes.
// RULE5: No Type 0 config primary out, secondary in.
// RULE6: Nonlinear address: disconnect after first transfer.
// RULE7: Positive medium decode only, never subtractive.
// RULE8: Data moves only when IRDY and TRDY.
// RULE9: Last phase: FRAME off with IRDY+TRDY/STOP.
// RULE10: Memory writes posted; VGA, I/O, config delayed.
// RULE11: Medium DEVSEL, TRDY next, room required first.
// RULE12: One DWORD per clock, no target waits.
// RULE13: Disconnect at boundary or full buffer.
// RULE14: Request destination bus once head holds data.
// RULE15: Grant plus idle: address, then data.
// RULE16: Master inserts no wait states while data.
// RULE17: Queue empties: last phase, restart later.
// RULE18: Disconnect or retry: resume remainder later.
// RULE19: Target abort: discard remaining write data.
// RULE20: Latency expiry without grant ends transfer.
// RULE21: Two 128-byte write buffers, one per direction.
// RULE22: Control bit picks cache line or 4KB.
// RULE23: Deliver in order with same address, enables.

// ----------------------------------------
// Synchronous FIFO with valid/ready on both sides
// ----------------------------------------
module post_fifo #(
  parameter int W = 38,
  parameter int DEPTH = 32,
  parameter int LW = 6
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  // Fill level
  output logic [LW-1:0] level_o
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [LW-1:0] level;
  logic push;
  logic pop;

  // Honest full and empty from the level count
  assign in_ready_o = (level != LW'(DEPTH));
  assign out_valid_o = (level != '0);
  assign out_data_o = mem[rd_ptr];
  assign level_o = level;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Storage; holds no reset since the level guards every read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers and level
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      level <= level + LW'(push) - LW'(pop);
    end
  end

endmodule

// ----------------------------------------
// Top: bus 0 is primary, bus 1 is secondary
// ----------------------------------------
module pci_bridge_write_forwarding #(
  parameter int DEPTH = pci_bridge_pkg::POST_DEPTH,
  parameter int LW = pci_bridge_pkg::LEVEL_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Bus pins, indexed by bus
  input wire pci_bridge_pkg::pci_in_t bus_i [2],
  output pci_bridge_pkg::tgt_out_t tgt_o [2],
  output pci_bridge_pkg::mst_out_t mst_o [2],
  // Settings: cfg_i indexed by source bus of the direction, cache line controls shared by both
  input wire pci_bridge_pkg::dir_cfg_t cfg_i [2],
  input wire logic cache_line_mode_i,
  input wire logic [7:0] cache_line_size_i
);

  typedef enum logic [2:0] {T_IDLE, T_DEC, T_DEV, T_DATA, T_STOP} tgt_state_t;
  typedef enum logic [2:0] {M_IDLE, M_ADDR, M_DATA, M_END, M_FLUSH} mst_state_t;

  localparam int EW = $bits(pci_bridge_pkg::post_entry_t);

  // Previous frame per bus, to spot an address phase
  logic [1:0] frame_prev_n;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      frame_prev_n <= 2'h3;
    end else begin
      frame_prev_n <= {bus_i[1].frame_n, bus_i[0].frame_n};
    end
  end

  // One posted path per direction: g is the source bus, 1-g the destination
  for (genvar g = 0; g < 2; g++) begin : g_dir
    pci_bridge_pkg::pci_in_t src;
    pci_bridge_pkg::pci_in_t dst;
    pci_bridge_pkg::post_entry_t in_ent;
    pci_bridge_pkg::post_entry_t head;
    tgt_state_t t_st;
    mst_state_t m_st;
    logic in_valid;
    logic in_ready;
    logic head_valid;
    logic pop;
    logic [LW-1:0] level;
    logic addr_phase;
    logic claim;
    logic in_window;
    logic is_vga;
    logic [31:0] t_addr;
    logic unaligned;
    logic cl_hit;
    logic page_hit;
    logic disc_now;
    logic t_xfer;
    logic [31:0] cur_addr;
    logic [3:0] cur_cmd;
    logic fin_q;
    logic final_now;
    logic [7:0] lat_cnt;
    logic lat_exp;
    logic [2:0] dev_cnt;
    logic m_xfer;
    logic head_ready;

    assign src = bus_i[g];
    assign dst = bus_i[1-g];

    // ----------------------------------------
    // Target side on the source bus
    // ----------------------------------------

    // Positive decode: only posted memory writes inside the window
    assign addr_phase = !src.frame_n && frame_prev_n[g] && (t_st == T_IDLE);
    assign in_window = (src.ad >= cfg_i[g].base) && (src.ad <= cfg_i[g].limit); // RULE7
    assign is_vga = cfg_i[g].vga_en && (src.ad >= pci_bridge_pkg::VGA_LO) && (src.ad <= pci_bridge_pkg::VGA_HI);
    // VGA, I/O and config writes are left to the delayed queue
    assign claim = addr_phase && in_window && !is_vga // RULE10
      && ((src.cbe_n == pci_bridge_pkg::CMD_MEM_WRITE) // RULE1 RULE2 RULE3 RULE4 RULE5
      || (src.cbe_n == pci_bridge_pkg::CMD_MEM_WRITE_INV))
      && (level <= LW'(DEPTH - 2)); // RULE11

    // Disconnect conditions on the current data phase
    assign unaligned = (t_addr[1:0] != 2'h0); // RULE6
    assign cl_hit = cache_line_mode_i && (cache_line_size_i != 8'h00)
      && (((t_addr[9:2] + 8'h01) & (cache_line_size_i - 8'h01)) == 8'h00); // RULE22
    assign page_hit = !cache_line_mode_i && (t_addr[11:2] == pci_bridge_pkg::PAGE_LAST_WORD);
    // A phase that takes the last free slot also disconnects
    assign disc_now = unaligned || cl_hit || page_hit || (level >= LW'(DEPTH - 1)); // RULE13
    assign t_xfer = (t_st == T_DATA) && !src.irdy_n; // RULE8

    // Target state: medium decode puts DEVSEL two clocks after the address
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        t_st <= T_IDLE;
      end else begin
        case (t_st)
          T_IDLE: begin
            if (claim) begin
              t_st <= T_DEC; // RULE11
            end
          end
          T_DEC: t_st <= T_DEV;
          T_DEV: t_st <= T_DATA;
          T_DATA: begin
            // Frame high at a transfer marks the final phase
            if (t_xfer && src.frame_n) begin
              t_st <= T_IDLE; // RULE9
            end else if (t_xfer && disc_now) begin
              t_st <= T_STOP;
            end
          end
          T_STOP: begin
            if (src.frame_n) begin
              t_st <= T_IDLE;
            end
          end
          default: t_st <= T_IDLE;
        endcase
      end
    end

    // Running target address, one DWORD per transfer
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        t_addr <= '0;
      end else if (claim) begin
        t_addr <= src.ad;
      end else if (t_xfer) begin
        t_addr <= t_addr + pci_bridge_pkg::DWORD_STEP;
      end
    end

    // Buffer fill: address entry at claim, then one word per transfer
    always_comb begin
      in_ent = '0;
      in_valid = 1'b0;
      if (claim) begin
        in_ent.first = 1'b1;
        in_ent.be_n = src.cbe_n;
        in_ent.dw = src.ad;
        in_valid = 1'b1;
      end else if (t_xfer) begin
        in_ent.last = src.frame_n || disc_now;
        in_ent.be_n = src.cbe_n; // RULE23
        in_ent.dw = src.ad;
        in_valid = 1'b1; // RULE12
      end
    end

    // Target drive; TRDY is never withheld while in the data state
    always_comb begin
      tgt_o[g].devsel_n = !((t_st == T_DEV) || (t_st == T_DATA) || (t_st == T_STOP)); // RULE11
      tgt_o[g].trdy_n = !(t_st == T_DATA); // RULE12
      tgt_o[g].stop_n = !((t_st == T_STOP) || ((t_st == T_DATA) && disc_now)); // RULE13
      tgt_o[g].oe_n = !((t_st == T_DEV) || (t_st == T_DATA) || (t_st == T_STOP));
    end

    // ----------------------------------------
    // Posted buffer, 128 bytes per direction
    // ----------------------------------------
    post_fifo #(
      .W(EW),
      .DEPTH(DEPTH),
      .LW(LW)
    ) u_fifo ( // RULE21
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(in_valid),
      .in_ready_o(in_ready),
      .in_data_i(in_ent),
      .out_valid_o(head_valid),
      .out_ready_i(pop),
      .out_data_o(head),
      .level_o(level)
    );

    // ----------------------------------------
    // Master side on the destination bus
    // ----------------------------------------

    // Head ready to go: an address entry needs a data word behind it
    assign head_ready = head_valid && (!head.first || (level >= LW'(2)));
    assign lat_exp = (lat_cnt >= cfg_i[g].lat_timer);
    // Final phase: tagged last, only word queued, or bus taken away
    assign final_now = head.last || (level == LW'(1)) // RULE17
      || (lat_exp && dst.gnt_n); // RULE20
    assign m_xfer = (m_st == M_DATA) && !dst.trdy_n; // RULE8

    // Pops: the address entry in the address phase, words on transfer
    always_comb begin
      case (m_st)
        M_ADDR: pop = head.first;
        M_DATA: pop = m_xfer;
        M_FLUSH: pop = head_valid && !head.first; // RULE19
        default: pop = 1'b0;
      endcase
    end

    // Master state machine
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        m_st <= M_IDLE;
      end else begin
        case (m_st)
          M_IDLE: begin
            if (head_ready && !dst.gnt_n && dst.frame_n && dst.irdy_n) begin
              m_st <= M_ADDR; // RULE15
            end
          end
          M_ADDR: m_st <= M_DATA;
          M_DATA: begin
            if (!dst.stop_n && dst.devsel_n) begin
              m_st <= M_FLUSH; // RULE19
            end else if (dst.devsel_n && (dev_cnt == 3'(pci_bridge_pkg::MABORT_CYC))) begin
              m_st <= M_FLUSH;
            end else if (m_xfer && (fin_q || final_now)) begin
              m_st <= M_END; // RULE9
            end else if (!dst.stop_n) begin
              m_st <= M_END; // RULE18
            end
          end
          M_END: m_st <= M_IDLE;
          M_FLUSH: begin
            if (!head_valid || head.first) begin
              m_st <= M_IDLE;
            end
          end
          default: m_st <= M_IDLE;
        endcase
      end
    end

    // Delivery address and command; a resumed burst keeps its place
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        cur_addr <= '0;
        cur_cmd <= pci_bridge_pkg::CMD_MEM_WRITE;
      end else if ((m_st == M_ADDR) && head.first) begin
        cur_addr <= head.dw; // RULE23
        cur_cmd <= head.be_n;
      end else if (m_xfer) begin
        cur_addr <= cur_addr + pci_bridge_pkg::DWORD_STEP; // RULE18
      end
    end

    // Final phase latch: FRAME never returns once released
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        fin_q <= 1'b0;
      end else if (m_st == M_DATA) begin
        fin_q <= fin_q || final_now; // RULE17
      end else begin
        fin_q <= 1'b0;
      end
    end

    // Latency and device select counters, started by the address phase
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        lat_cnt <= '0;
        dev_cnt <= '0;
      end else if (m_st == M_ADDR) begin
        lat_cnt <= 8'h01;
        dev_cnt <= 3'h1;
      end else if (m_st == M_DATA) begin
        if (!lat_exp) begin
          lat_cnt <= lat_cnt + 8'h01;
        end
        if (dst.devsel_n && (dev_cnt != 3'(pci_bridge_pkg::MABORT_CYC))) begin
          dev_cnt <= dev_cnt + 3'h1;
        end
      end
    end

    // Master drive; IRDY is held through every data phase
    always_comb begin
      mst_o[1-g].req_n = !head_ready; // RULE14
      mst_o[1-g].frame_n = !((m_st == M_ADDR) || ((m_st == M_DATA) && !fin_q && !final_now)); // RULE9
      mst_o[1-g].irdy_n = !(m_st == M_DATA); // RULE16
      mst_o[1-g].ctl_oe_n = !((m_st == M_ADDR) || (m_st == M_DATA) || (m_st == M_END));
      mst_o[1-g].ad_oe_n = !((m_st == M_ADDR) || (m_st == M_DATA));
      if (m_st == M_ADDR) begin
        // Only stored memory write commands are ever issued
        mst_o[1-g].ad = head.first ? head.dw : cur_addr; // RULE15
        mst_o[1-g].cbe_n = head.first ? head.be_n : cur_cmd; // RULE1 RULE2 RULE5
      end else begin
        mst_o[1-g].ad = head.dw; // RULE16
        mst_o[1-g].cbe_n = head.be_n; // RULE23
      end
    end
  end

endmodule

// ---- verif/pci_bridge_write_forwarding_monitor.sv ----
// Port checker for the posted write forwarding core, bound to its top
module pci_bridge_write_forwarding_monitor #(
  parameter int DEPTH = 32,
  parameter int LW = 6
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Watched ports
  input wire pci_bridge_pkg::pci_in_t bus_i [2],
  input wire pci_bridge_pkg::tgt_out_t tgt_o [2],
  input wire pci_bridge_pkg::mst_out_t mst_o [2],
  input wire pci_bridge_pkg::dir_cfg_t cfg_i [2]
);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Primary address phase the bridge must leave alone
  sequence s_foreign;
    $fell(bus_i[0].frame_n) && (bus_i[0].cbe_n != pci_bridge_pkg::CMD_MEM_WRITE &&
      bus_i[0].cbe_n != pci_bridge_pkg::CMD_MEM_WRITE_INV || cfg_i[0].vga_en &&
      bus_i[0].ad >= pci_bridge_pkg::VGA_LO && bus_i[0].ad <= pci_bridge_pkg::VGA_HI);
  endsequence

  // First word accepted while the secondary master is idle
  sequence s_first_store;
    $fell(tgt_o[0].trdy_n) && !bus_i[0].irdy_n && mst_o[1].ctl_oe_n;
  endsequence

  // Bridge opens a transfer on the secondary bus
  sequence s_mst_addr;
    $fell(mst_o[1].frame_n) && !mst_o[1].ctl_oe_n;
  endsequence

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_medium_devsel: assert property ($fell(tgt_o[0].devsel_n) |->
    $past(bus_i[0].frame_n, 3) && !$past(bus_i[0].frame_n, 2))
    else $error("select not two clocks after address");
  a_trdy_follows: assert property ($fell(tgt_o[0].devsel_n) |=> !tgt_o[0].trdy_n)
    else $error("ready missing after select");
  a_foreign_ignored: assert property (s_foreign |-> ##2 tgt_o[0].devsel_n [*2])
    else $error("foreign command claimed");
  a_no_target_waits: assert property (!tgt_o[0].trdy_n && !bus_i[0].irdy_n &&
    !bus_i[0].frame_n && tgt_o[0].stop_n |=> !tgt_o[0].trdy_n)
    else $error("target wait state inserted");
  a_misaligned_disconnect: assert property ($fell(tgt_o[0].trdy_n) &&
    $past(bus_i[0].ad[1:0], 3) != 2'h0 |-> !tgt_o[0].stop_n)
    else $error("no disconnect on misaligned start");
  a_request_follows: assert property (s_first_store |->
    ##[1:4] (!mst_o[1].req_n || !mst_o[1].ctl_oe_n))
    else $error("no request after stored word");
  a_master_start: assert property (s_mst_addr |-> $past(bus_i[1].gnt_n) == 1'b0 &&
    $past(bus_i[1].frame_n) && $past(bus_i[1].irdy_n) ##1 !mst_o[1].irdy_n)
    else $error("bad master start");
  a_no_master_waits: assert property (!mst_o[1].ctl_oe_n && !mst_o[1].irdy_n &&
    !mst_o[1].frame_n && !bus_i[1].trdy_n && bus_i[1].stop_n |=> !mst_o[1].irdy_n)
    else $error("master wait state inserted");
  a_stop_ends: assert property (!mst_o[1].ctl_oe_n && !mst_o[1].irdy_n &&
    !bus_i[1].stop_n |=> mst_o[1].frame_n && mst_o[1].irdy_n)
    else $error("master kept going after stop");
endmodule

bind pci_bridge_write_forwarding pci_bridge_write_forwarding_monitor #(.DEPTH(DEPTH), .LW(LW)) mon (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .tgt_o(tgt_o), .mst_o(mst_o), .cfg_i(cfg_i));

// ---- verif/pci_target_model.sv ----
// Behavioural target and arbiter standing on the secondary bus
module pci_target_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Resolved bus and the bridge request
  input wire pci_bridge_pkg::pci_in_t bus_i,
  input wire logic req_n_i,
  // Behaviour: 0 accept, 1 disconnect with data, 2 target abort
  input wire logic [1:0] mode_i,
  input wire logic hold_gnt_i,
  // Answers, high when released
  output logic devsel_n_o,
  output logic trdy_n_o,
  output logic stop_n_o,
  output logic gnt_n_o
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic act;
  logic [31:0] adr;
  logic [67:0] got_q [$];

  // Grant a clock after request, or withheld to stall the bridge
  always @(posedge clk_i) begin
    gnt_n_o <= !rst_n_i | req_n_i | hold_gnt_i;
  end

  // Claim at once, take words, let go when the bus is idle again
  always @(posedge clk_i) begin
    if (!rst_n_i || (act && bus_i.frame_n && bus_i.irdy_n)) begin
      act <= 1'b0;
      {devsel_n_o, trdy_n_o, stop_n_o} <= 3'h7;
    end else if (!act && !bus_i.frame_n) begin
      act <= 1'b1;
      adr <= bus_i.ad;
      {devsel_n_o, trdy_n_o, stop_n_o} <= (mode_i == 2'h2) ? 3'h6 : {2'h0, mode_i != 2'h1};
    end else if (act && !bus_i.irdy_n && !trdy_n_o) begin
      got_q.push_back({adr, bus_i.cbe_n, bus_i.ad});
      adr <= adr + 32'h4;
      trdy_n_o <= bus_i.frame_n || mode_i == 2'h1;
    end
  end
endmodule

// ---- verif/pci_bridge_write_forwarding_tb.sv ----
// Self-checking bench: primary initiator drives bursts, model takes them on secondary
module pci_bridge_write_forwarding_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam int DEPTH = 8;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic frame_n = 1'b1, irdy_n = 1'b1, cl_mode = 1'b0, hold = 1'b0;
  logic [3:0] cbe_n = 4'h0;
  logic [31:0] ad = 32'h0;
  logic [1:0] mode = 2'h0;
  logic dv1, tr1, st1, gn1;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  pci_bridge_pkg::pci_in_t bus [2];
  pci_bridge_pkg::tgt_out_t tgt [2];
  pci_bridge_pkg::mst_out_t mst [2];
  pci_bridge_pkg::dir_cfg_t cfg [2];

  // Pull-ups hold released control lines high; released ad shows inverted junk
  assign bus[0] = {frame_n, irdy_n, tgt[0].trdy_n | tgt[0].oe_n, tgt[0].stop_n | tgt[0].oe_n,
    tgt[0].devsel_n | tgt[0].oe_n, 1'b1, cbe_n, ad};
  assign bus[1] = {mst[1].frame_n | mst[1].ctl_oe_n, mst[1].irdy_n | mst[1].ctl_oe_n, tr1, st1, dv1, gn1,
    mst[1].ad_oe_n ? ~mst[1].cbe_n : mst[1].cbe_n, mst[1].ad_oe_n ? ~mst[1].ad : mst[1].ad};

  pci_bridge_write_forwarding #(.DEPTH(DEPTH), .LW(4)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .bus_i(bus), .tgt_o(tgt), .mst_o(mst), .cfg_i(cfg), .cache_line_mode_i(cl_mode),
    .cache_line_size_i(8'h04));
  pci_target_model far_end (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus[1]), .req_n_i(mst[1].req_n),
    .mode_i(mode), .hold_gnt_i(hold), .devsel_n_o(dv1), .trdy_n_o(tr1), .stop_n_o(st1), .gnt_n_o(gn1));

  always #50 clk_i = ~clk_i;

  // Hang guard, far above the few hundred clocks the run needs
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [67:0] seen, input logic [67:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d, err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One burst on the primary bus; data word is the inverted address
  task automatic wr(input logic [31:0] a, input logic [3:0] c, input int n, output int got);
    int k;
    got = 0;
    repeat (2) @(posedge clk_i);
    frame_n <= 1'b0;
    ad <= a;
    cbe_n <= c;
    @(posedge clk_i);
    irdy_n <= 1'b0;
    frame_n <= n == 1;
    ad <= ~a;
    cbe_n <= 4'h0;
    for (k = 0; k < 40; k++) begin
      @(posedge clk_i);
      if (!bus[0].trdy_n)
        got++;
      if (!bus[0].stop_n || (!bus[0].trdy_n && bus[0].frame_n) || (k > 6 && bus[0].devsel_n))
        break;
      if (!bus[0].trdy_n) begin
        frame_n <= got >= n - 1;
        ad <= ~(a + 32'(4 * got));
      end
    end
    // Stopped with frame still low: one closing phase with frame high
    frame_n <= 1'b1;
    if (!bus[0].frame_n)
      @(posedge clk_i);
    irdy_n <= 1'b1;
  endtask

  // Wait for n words and an idle master, then judge order, address and enables
  task automatic expect_q(input logic [31:0] a, input int n);
    int k;
    for (k = 0; k < 300 && !(far_end.got_q.size() >= n && mst[1].req_n && mst[1].ctl_oe_n); k++)
      @(posedge clk_i);
    chk("words delivered", 68'(far_end.got_q.size()), 68'(n));
    for (k = 0; k < n && k < far_end.got_q.size(); k++)
      chk("delivered word", far_end.got_q[k], {a + 32'(4 * k), 4'h0, ~(a + 32'(4 * k))});
    far_end.got_q.delete();
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_basic();
    int got;
    wr(32'h0000_2000, pci_bridge_pkg::CMD_MEM_WRITE, 1, got);
    chk("single transfers", 68'(got), 68'h1);
    expect_q(32'h0000_2000, 1);
    wr(32'h0000_2100, pci_bridge_pkg::CMD_MEM_WRITE_INV, 5, got);
    chk("burst transfers", 68'(got), 68'h5);
    expect_q(32'h0000_2100, 5);
    $display("basic done");
  endtask

  // Other commands, a VGA write and an address below the window stay unclaimed
  task automatic t_ignore();
    int got;
    for (int c = 0; c < 16; c++) begin
      if (c != 7 && c != 15) begin
        wr(32'h0000_3000, 4'(c), 1, got);
        chk("foreign transfers", 68'(got), 68'h0);
      end
    end
    wr(pci_bridge_pkg::VGA_LO, pci_bridge_pkg::CMD_MEM_WRITE, 1, got);
    chk("vga transfers", 68'(got), 68'h0);
    wr(32'h0000_0800, pci_bridge_pkg::CMD_MEM_WRITE, 1, got);
    chk("outside transfers", 68'(got), 68'h0);
    expect_q(32'h0, 0);
    $display("ignore done");
  endtask

  // Misaligned start, cache line edge, last word of a 4KB page
  task automatic t_bounds();
    logic [32:0] tbl [3] = '{{1'b0, 32'h0000_1001}, {1'b1, 32'h0000_1008}, {1'b0, 32'h0000_1ff8}};
    int exp [3] = '{1, 2, 2};
    int got;
    for (int i = 0; i < 3; i++) begin
      cl_mode <= tbl[i][32];
      wr(tbl[i][31:0], pci_bridge_pkg::CMD_MEM_WRITE, 6, got);
      chk("bounded transfers", 68'(got), 68'(exp[i]));
      expect_q(tbl[i][31:0], exp[i]);
    end
    cl_mode <= 1'b0;
    $display("bounds done");
  endtask

  // Grant withheld: the buffer fills and the initiator is cut off
  task automatic t_full();
    int got;
    hold <= 1'b1;
    wr(32'h0000_4000, pci_bridge_pkg::CMD_MEM_WRITE, 12, got);
    chk("transfers until full", 68'(got), 68'(DEPTH - 1));
    chk("request while filling", 68'(mst[1].req_n), 68'h0);
    hold <= 1'b0;
    expect_q(32'h0000_4000, DEPTH - 1);
    $display("full done");
  endtask

  // Far side disconnects after each word; remainder resent later
  task automatic t_retry();
    int got;
    mode <= 2'h1;
    wr(32'h0000_5000, pci_bridge_pkg::CMD_MEM_WRITE, 3, got);
    chk("retry source transfers", 68'(got), 68'h3);
    expect_q(32'h0000_5000, 3);
    mode <= 2'h0;
    $display("retry done");
  endtask

  // Far side aborts: queued words dropped, later traffic still flows
  task automatic t_abort();
    int got;
    hold <= 1'b1;
    mode <= 2'h2;
    wr(32'h0000_6000, pci_bridge_pkg::CMD_MEM_WRITE, 3, got);
    hold <= 1'b0;
    expect_q(32'h0000_6000, 0);
    mode <= 2'h0;
    wr(32'h0000_6100, pci_bridge_pkg::CMD_MEM_WRITE, 1, got);
    expect_q(32'h0000_6100, 1);
    $display("abort done");
  endtask

  // Main sequence
  initial begin
    cfg[0] = '{32'h0000_1000, 32'h0fff_ffff, 1'b1, 8'h20};
    cfg[1] = '{32'hffff_0000, 32'hffff_fff0, 1'b1, 8'h20};
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_basic();
    t_ignore();
    t_bounds();
    t_full();
    t_retry();
    t_abort();
    stop_test();
  end
endmodule
